// ==== hw/tppwm_defines.svh ====
// Constants of the three-phase PWM timer: offsets, field positions, resets.
// Assumes inclusion wherever these constants are used.
`ifndef TPPWM_DEFINES_SVH
`define TPPWM_DEFINES_SVH

// **********
// Register offsets on the 4-bit parallel address.
// **********
`define TPPWM_ADDR_PERIOD   4'h0
`define TPPWM_ADDR_DUTY1    4'h1
`define TPPWM_ADDR_DUTY2    4'h2
`define TPPWM_ADDR_DUTY3    4'h3
`define TPPWM_ADDR_DEAD     4'h4
`define TPPWM_ADDR_MINP     4'h5
`define TPPWM_ADDR_STATUS   4'h6
`define TPPWM_ADDR_COUNT    4'h7

// **********
// Widths, reset values and timing counts.
// **********
`define TPPWM_CNT_W         12
`define TPPWM_SET_W         7
`define TPPWM_PERIOD_RST    12'h000
`define TPPWM_DUTY_RST      12'h000
`define TPPWM_SET_RST       7'h00
`define TPPWM_LEAD_CLKS     12'h003
`define TPPWM_PERIOD_MIN    12'h002

// **********
// Status register field positions.
// **********
`define TPPWM_ST_WRITTEN_LO 0
`define TPPWM_ST_RUNNING    3
`define TPPWM_ST_DOWN       4
`define TPPWM_ST_STOP       5

`endif

// ==== hw/tppwm_leg.sv ====
// One inverter leg: deadtime insertion and active-low output stage.
// Assumes controls synchronous to core_clk.
`timescale 1ns/100ps

module tppwm_leg
  import tppwm_pkg::*;
#(
  parameter int DT_W = `TPPWM_SET_W
) (
  // Clock and reset.
  input  wire logic            core_clk,
  input  wire logic            rst,
  // Control.
  input  wire logic            ideal_on,
  input  wire logic            enable,
  input  wire logic            stop,
  input  wire logic [DT_W-1:0] dead_clks,
  // Gate drive, active low.
  output logic                 main_out_n,
  output logic                 comp_out_n
);

  logic            prev_reg;
  logic            prev_next;
  logic [DT_W-1:0] age_reg;
  logic [DT_W-1:0] age_next;
  logic            main_reg;
  logic            main_next;
  logic            comp_reg;
  logic            comp_next;
  logic            settled;
  logic            main_on;
  logic            comp_on;

  // Age counts clocks since the ideal signal last changed, saturating.
  always_comb begin
    prev_next = ideal_on;
    if (ideal_on != prev_reg) begin
      age_next = {{(DT_W-1){1'b0}}, 1'b1};
    end else if (age_reg != {DT_W{1'b1}}) begin
      age_next = age_reg + 1'b1;
    end else begin
      age_next = age_reg;
    end
    // The change clock counts as age zero, so a switch waits the full
    // deadtime after its partner turns off and a leg never shorts.
    settled = (ideal_on == prev_reg) ? (age_reg >= dead_clks)
                                     : (dead_clks == '0);
    main_on = ideal_on && settled;                    // see RULE_09
    comp_on = !ideal_on && settled;
    // Shutdown wins over everything and acts on the next edge.
    if (stop || !enable) begin                        // see RULE_13
      main_next = 1'b1;
      comp_next = 1'b1;
    end else begin
      main_next = !main_on;                           // see RULE_03
      comp_next = !comp_on;
    end
  end

  // State registers; outputs rest high (off) in reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_reg <= 1'b0;
      age_reg  <= '0;
      main_reg <= 1'b1;                               // see RULE_18
      comp_reg <= 1'b1;                               // see RULE_18
    end else begin
      prev_reg <= prev_next;
      age_reg  <= age_next;
      main_reg <= main_next;
      comp_reg <= comp_next;
    end
  end

  assign main_out_n = main_reg;
  assign comp_out_n = comp_reg;

endmodule : tppwm_leg

// ==== hw/tppwm_pkg.sv ====
// Types shared by the three-phase PWM timer modules.
// Assumes the defines header sits in the include path.
`include "tppwm_defines.svh"

package tppwm_pkg;

  // Count direction of the centre-based up/down counter.
  typedef enum logic {
    TPPWM_UP,
    TPPWM_DOWN
  } tppwm_dir_t;

  // A 12-bit count value.
  typedef logic [`TPPWM_CNT_W-1:0] tppwm_cnt_t;

endpackage : tppwm_pkg

// ==== hw/tppwm_timer.sv ====
// Three-phase centre-based PWM timer with its parallel register port.
// Assumes inputs synchronous to core_clk; data pins resolved outside.
//
// Notes on behaviour
// RULE_01: Edges are timed by a 12-bit counter stepping once per clock.
// RULE_02: Three centred duty signals each get a complement, six outputs.
// RULE_03: All six outputs are active low; high means switch off.
// RULE_04: Cycle length in clocks comes from the period register.
// RULE_05: Each leg is on for its duty value in clocks per cycle.
// RULE_06: A one-clock sync pulse marks the start of every cycle; the code pulses only on cycles that run (running_next set).
// RULE_07: Host writes all three duties at least four clocks before start.
// RULE_08: New duties apply only after all three are rewritten.
// RULE_09: Deadtime separates each output edge from its complement edge.
// RULE_10: Deadtime setting is 7 bits, LSB forced zero, 0 to 126 clocks.
// RULE_11: Minimum-pulse setting is 7 bits, threshold of 0 to 127 clocks.
// RULE_12: Shorter pulses are deleted: main off, complement on all cycle.
// RULE_13: Shutdown high forces all outputs high within one clock.
// RULE_14: Shutdown low resumes normal outputs within one clock.
// RULE_15: Unused shutdown input must be held low by the system.
// RULE_16: The timer runs alone, coupled to no other unit.
// RULE_17: An up/down counter centres each on-time in the cycle.
// RULE_18: Outputs stay high in reset and until duties are loaded.
`timescale 1ns/100ps

module tppwm_timer
  import tppwm_pkg::*;
#(
  parameter int CNT_W = `TPPWM_CNT_W
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Parallel register port.
  input  wire logic             cs_n,
  input  wire logic             rd_n,
  input  wire logic             wr_n,
  input  wire logic [3:0]       addr,
  input  wire logic [CNT_W-1:0] data_in,
  output logic      [CNT_W-1:0] data_out,
  output logic                  data_oe_n,
  // External shutdown.
  input  wire logic             shutdown_in,
  // Gate drive outputs, active low.
  output logic                  leg1_out_n,
  output logic                  leg1_complement_out_n,
  output logic                  leg2_out_n,
  output logic                  leg2_complement_out_n,
  output logic                  leg3_out_n,
  output logic                  leg3_complement_out_n,
  // Cycle marker.
  output logic                  cycle_sync_pulse
);

  // **********
  // Helpers.
  // **********

  // Thresholds for one leg: the on-time is split into an up-phase share
  // (the larger half) and a down-phase share, so the pulse sits centred.
  function automatic logic [2*CNT_W-1:0] leg_thr(
    input logic [CNT_W-1:0] duty,
    input logic [CNT_W-1:0] up_len,
    input logic [CNT_W-1:0] dn_len
  );
    logic [CNT_W-1:0] on_up;
    logic [CNT_W-1:0] on_dn;
    logic [CNT_W-1:0] t_up;
    logic [CNT_W-1:0] t_dn;
    on_up = (duty >> 1) + {{(CNT_W-1){1'b0}}, duty[0]};
    on_dn = duty - on_up;
    t_up  = (on_up >= up_len) ? '0 : up_len - on_up;  // see RULE_17
    t_dn  = (on_dn >= dn_len) ? '0 : dn_len - on_dn;  // see RULE_17
    return {t_up, t_dn};
  endfunction : leg_thr

  // **********
  // Registers written by the host.
  // **********

  logic [CNT_W-1:0]         period_reg;
  logic [CNT_W-1:0]         period_next;
  logic [CNT_W-1:0]         duty_reg [3];
  logic [CNT_W-1:0]         duty_next [3];
  logic [`TPPWM_SET_W-1:0]  deadtime_setting_reg;
  logic [`TPPWM_SET_W-1:0]  deadtime_setting_next;
  logic [`TPPWM_SET_W-1:0]  minimum_pulse_setting_reg;
  logic [`TPPWM_SET_W-1:0]  minimum_pulse_setting_next;
  logic [2:0]               written_reg;
  logic [2:0]               written_next;
  logic [CNT_W-1:0]         data_out_reg;
  logic [CNT_W-1:0]         data_out_next;
  logic                     oe_n_reg;
  logic                     oe_n_next;
  logic                     wr_hit;
  logic                     rd_hit;
  logic                     take_duty;

  // **********
  // Counter and per-cycle state.
  // **********

  tppwm_dir_t               dir_reg;
  tppwm_dir_t               dir_next;
  logic [CNT_W-1:0]         cnt_reg;
  logic [CNT_W-1:0]         cnt_next;
  logic [CNT_W-1:0]         up_len_reg;
  logic [CNT_W-1:0]         up_len_next;
  logic [CNT_W-1:0]         dn_len_reg;
  logic [CNT_W-1:0]         dn_len_next;
  logic [CNT_W-1:0]         stage_reg [3];
  logic [CNT_W-1:0]         stage_next [3];
  logic                     staged_reg;
  logic                     staged_next;
  logic [CNT_W-1:0]         thr_up_reg [3];
  logic [CNT_W-1:0]         thr_up_next [3];
  logic [CNT_W-1:0]         thr_dn_reg [3];
  logic [CNT_W-1:0]         thr_dn_next [3];
  logic [2:0]               del_reg;
  logic [2:0]               del_next;
  logic                     running_reg;
  logic                     running_next;
  logic                     sync_reg;
  logic                     sync_next;
  logic                     wrap;
  logic                     latch_pt;
  logic [CNT_W-1:0]         lead_idx;
  logic [CNT_W-1:0]         new_up;
  logic [CNT_W-1:0]         new_dn;
  logic [2*CNT_W-1:0]       thr_pair;
  logic [2:0]               ideal;
  logic [`TPPWM_SET_W-1:0]  dead_clks;

  // **********
  // Register port.
  // **********

  // Bus decode; a write is taken on every clock cs_n and wr_n are both low.
  always_comb begin
    wr_hit = !cs_n && !wr_n;
    rd_hit = !cs_n && !rd_n;
    period_next                = period_reg;
    duty_next                  = duty_reg;
    deadtime_setting_next      = deadtime_setting_reg;
    minimum_pulse_setting_next = minimum_pulse_setting_reg;
    written_next               = take_duty ? 3'h0 : written_reg;
    if (wr_hit) begin
      if (addr == `TPPWM_ADDR_PERIOD) begin
        period_next = data_in;                          // see RULE_04
      end else if (addr == `TPPWM_ADDR_DUTY1) begin
        duty_next[0]    = data_in;
        written_next[0] = 1'b1;                         // see RULE_08
      end else if (addr == `TPPWM_ADDR_DUTY2) begin
        duty_next[1]    = data_in;
        written_next[1] = 1'b1;                         // see RULE_08
      end else if (addr == `TPPWM_ADDR_DUTY3) begin
        duty_next[2]    = data_in;
        written_next[2] = 1'b1;                         // see RULE_08
      end else if (addr == `TPPWM_ADDR_DEAD) begin
        deadtime_setting_next = data_in[`TPPWM_SET_W-1:0];  // see RULE_10
      end else if (addr == `TPPWM_ADDR_MINP) begin
        minimum_pulse_setting_next = data_in[`TPPWM_SET_W-1:0]; // see RULE_11
      end
    end
    // Read data is registered, so it appears one clock after the strobe.
    oe_n_next     = !rd_hit;
    data_out_next = '0;
    if (addr == `TPPWM_ADDR_PERIOD) begin
      data_out_next = period_reg;
    end else if (addr == `TPPWM_ADDR_DUTY1) begin
      data_out_next = duty_reg[0];
    end else if (addr == `TPPWM_ADDR_DUTY2) begin
      data_out_next = duty_reg[1];
    end else if (addr == `TPPWM_ADDR_DUTY3) begin
      data_out_next = duty_reg[2];
    end else if (addr == `TPPWM_ADDR_DEAD) begin
      data_out_next = {5'h00, deadtime_setting_reg[`TPPWM_SET_W-1:1], 1'b0};
    end else if (addr == `TPPWM_ADDR_MINP) begin
      data_out_next = {5'h00, minimum_pulse_setting_reg};
    end else if (addr == `TPPWM_ADDR_STATUS) begin
      data_out_next[`TPPWM_ST_WRITTEN_LO +: 3] = written_reg;
      data_out_next[`TPPWM_ST_RUNNING]         = running_reg;
      data_out_next[`TPPWM_ST_DOWN]            = (dir_reg == TPPWM_DOWN);
      data_out_next[`TPPWM_ST_STOP]            = shutdown_in;
    end else if (addr == `TPPWM_ADDR_COUNT) begin
      data_out_next = cnt_reg;
    end
  end

  // Register port state.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      period_reg                <= `TPPWM_PERIOD_RST;
      duty_reg                  <= '{default: `TPPWM_DUTY_RST};
      deadtime_setting_reg      <= `TPPWM_SET_RST;
      minimum_pulse_setting_reg <= `TPPWM_SET_RST;
      written_reg               <= 3'h0;
      data_out_reg              <= '0;
      oe_n_reg                  <= 1'b1;
    end else begin
      period_reg                <= period_next;
      duty_reg                  <= duty_next;
      deadtime_setting_reg      <= deadtime_setting_next;
      minimum_pulse_setting_reg <= minimum_pulse_setting_next;
      written_reg               <= written_next;
      data_out_reg              <= data_out_next;
      oe_n_reg                  <= oe_n_next;
    end
  end

  // **********
  // Centre-based counter and cycle update.
  // **********

  // The counter runs up through the first half of the cycle and back
  // down through the second; nothing outside the timer steers it.
  always_comb begin
    new_up   = (period_reg >> 1) + {{(CNT_W-1){1'b0}}, period_reg[0]};
    new_dn   = period_reg - new_up;
    wrap     = (dir_reg == TPPWM_DOWN) && (cnt_reg == '0); // see RULE_16
    lead_idx = (dn_len_reg > `TPPWM_LEAD_CLKS) ? `TPPWM_LEAD_CLKS
                                               : dn_len_reg - 1'b1;
    latch_pt = (dir_reg == TPPWM_DOWN) && (cnt_reg == lead_idx);
    // Duties are taken four clocks ahead of the start, and only as a set.
    take_duty   = latch_pt && (written_reg == 3'h7);    // see RULE_08
    stage_next  = take_duty ? duty_reg : stage_reg;
    staged_next = staged_reg || take_duty;
    dir_next    = dir_reg;
    cnt_next    = cnt_reg;
    up_len_next = up_len_reg;
    dn_len_next = dn_len_reg;
    thr_up_next = thr_up_reg;
    thr_dn_next = thr_dn_reg;
    del_next    = del_reg;
    running_next = running_reg;
    if (wrap) begin
      // Period applies from the new cycle; too short a period idles.
      up_len_next  = new_up;                            // see RULE_04
      dn_len_next  = new_dn;
      dir_next     = TPPWM_UP;
      cnt_next     = '0;
      running_next = staged_reg
                     && (period_reg >= `TPPWM_PERIOD_MIN); // see RULE_18
      for (int i = 0; i < 3; i++) begin
        thr_pair       = leg_thr(stage_reg[i], new_up, new_dn);
        thr_up_next[i] = thr_pair[2*CNT_W-1:CNT_W];     // see RULE_05
        thr_dn_next[i] = thr_pair[CNT_W-1:0];
        del_next[i]    = (stage_reg[i] <
                          {5'h00, minimum_pulse_setting_reg}); // see RULE_12
      end
    end else if (dir_reg == TPPWM_UP) begin
      if (cnt_reg + 1'b1 >= up_len_reg) begin
        dir_next = TPPWM_DOWN;
        cnt_next = dn_len_reg - 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;                      // see RULE_01
      end
    end else begin
      cnt_next = cnt_reg - 1'b1;                        // see RULE_17
    end
    thr_pair = '0;
    sync_next = wrap && running_next;                   // see RULE_06
  end

  // Counter state; reset parks at the end of a cycle so one starts next.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dir_reg     <= TPPWM_DOWN;
      cnt_reg     <= '0;
      up_len_reg  <= '0;
      dn_len_reg  <= '0;
      stage_reg   <= '{default: '0};
      staged_reg  <= 1'b0;
      thr_up_reg  <= '{default: '0};
      thr_dn_reg  <= '{default: '0};
      del_reg     <= 3'h7;
      running_reg <= 1'b0;
      sync_reg    <= 1'b0;
    end else begin
      dir_reg     <= dir_next;
      cnt_reg     <= cnt_next;
      up_len_reg  <= up_len_next;
      dn_len_reg  <= dn_len_next;
      stage_reg   <= stage_next;
      staged_reg  <= staged_next;
      thr_up_reg  <= thr_up_next;
      thr_dn_reg  <= thr_dn_next;
      del_reg     <= del_next;
      running_reg <= running_next;
      sync_reg    <= sync_next;
    end
  end

  // **********
  // Leg outputs.
  // **********

  // Ideal leg signals: on inside the centred window, never when deleted.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (del_reg[i] || !running_reg) begin
        ideal[i] = 1'b0;                                // see RULE_12
      end else if (dir_reg == TPPWM_UP) begin
        ideal[i] = (cnt_reg >= thr_up_reg[i]);          // see RULE_17
      end else begin
        ideal[i] = (cnt_reg >= thr_dn_reg[i]);          // see RULE_17
      end
    end
    dead_clks = {deadtime_setting_reg[`TPPWM_SET_W-1:1], 1'b0}; // see RULE_10
  end

  // Each leg yields a main output and its complement.
  tppwm_leg u_leg1 (                                    // see RULE_02
    .core_clk(core_clk), .rst(rst), .ideal_on(ideal[0]),
    .enable(running_reg), .stop(shutdown_in),           // see RULE_14
    .dead_clks(dead_clks), .main_out_n(leg1_out_n),
    .comp_out_n(leg1_complement_out_n)
  );

  tppwm_leg u_leg2 (
    .core_clk(core_clk), .rst(rst), .ideal_on(ideal[1]),
    .enable(running_reg), .stop(shutdown_in), .dead_clks(dead_clks),
    .main_out_n(leg2_out_n), .comp_out_n(leg2_complement_out_n)
  );

  tppwm_leg u_leg3 (
    .core_clk(core_clk), .rst(rst), .ideal_on(ideal[2]),
    .enable(running_reg), .stop(shutdown_in), .dead_clks(dead_clks),
    .main_out_n(leg3_out_n), .comp_out_n(leg3_complement_out_n)
  );

  assign data_out         = data_out_reg;
  assign data_oe_n        = oe_n_reg;
  assign cycle_sync_pulse = sync_reg;

endmodule : tppwm_timer

// ==== tb/tppwm_asserts.sv ====
// Checker for the PWM timer: timing relations seen at its top ports.
// Assumes a bind onto tppwm_timer, one clock and a synchronous reset.
`timescale 1ns/100ps
`include "tppwm_defines.svh"

module tppwm_asserts #(
  parameter int CNT_W = 12
) (
  // Clock and reset.
  input wire logic             core_clk,
  input wire logic             rst,
  // Bus and shutdown.
  input wire logic             cs_n,
  input wire logic             rd_n,
  input wire logic [3:0]       addr,
  input wire logic [CNT_W-1:0] data_out,
  input wire logic             data_oe_n,
  input wire logic             shutdown_in,
  // Gate drive and cycle marker.
  input wire logic             leg1_out_n,
  input wire logic             leg1_complement_out_n,
  input wire logic             leg2_out_n,
  input wire logic             leg2_complement_out_n,
  input wire logic             leg3_out_n,
  input wire logic             leg3_complement_out_n,
  input wire logic             cycle_sync_pulse
);
  logic all_off;
  logic both_on;
  logic rd_now;

  // Gate line summaries and the sampled read strobe.
  assign all_off = &{leg1_out_n, leg1_complement_out_n, leg2_out_n,
                     leg2_complement_out_n, leg3_out_n,
                     leg3_complement_out_n};
  assign both_on = !(leg1_out_n | leg1_complement_out_n)
                 | !(leg2_out_n | leg2_complement_out_n)
                 | !(leg3_out_n | leg3_complement_out_n);
  assign rd_now  = !cs_n && !rd_n;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Reads of the two setting registers.
  sequence dead_read;
    rd_now && addr == `TPPWM_ADDR_DEAD;
  endsequence
  sequence minp_read;
    rd_now && addr == `TPPWM_ADDR_MINP;
  endsequence

  // **********
  // Gate drive and cycle marker
  // **********
  a_shutdown_off: assert property (shutdown_in |=> all_off)
    else $error("outputs on in shutdown");
  a_leg_overlap: assert property (!both_on)
    else $error("leg shoot-through");
  a_sync_single: assert property (
    cycle_sync_pulse |=> !cycle_sync_pulse)
    else $error("sync too wide");
  a_reset_exit: assert property (
    $fell(rst) |-> all_off && !cycle_sync_pulse)
    else $error("outputs on after reset");

  // **********
  // Register port
  // **********
  a_read_answer: assert property (rd_now |=> !data_oe_n)
    else $error("read not answered");
  a_oe_cause: assert property (!data_oe_n |-> $past(rd_now))
    else $error("drive without read");
  a_unmapped_zero: assert property (rd_now && addr[3] |=> data_out == '0)
    else $error("unmapped read nonzero");
  a_dead_even: assert property (
    dead_read |=> data_out[0] == 1'b0 && data_out[CNT_W-1:7] == '0)
    else $error("bad deadtime readback");
  a_minp_width: assert property (
    minp_read |=> data_out[CNT_W-1:7] == '0)
    else $error("bad min pulse readback");
endmodule : tppwm_asserts

bind tppwm_timer tppwm_asserts #(.CNT_W(CNT_W)) u_asserts (
  .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
  .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n),
  .shutdown_in(shutdown_in), .leg1_out_n(leg1_out_n),
  .leg1_complement_out_n(leg1_complement_out_n), .leg2_out_n(leg2_out_n),
  .leg2_complement_out_n(leg2_complement_out_n), .leg3_out_n(leg3_out_n),
  .leg3_complement_out_n(leg3_complement_out_n),
  .cycle_sync_pulse(cycle_sync_pulse)
);

// ==== tb/tppwm_gate_model.sv ====
// Gate driver model of the inverter: on-clocks per switch per cycle.
// Assumes the six active-low gate lines and the timer's cycle marker.
`timescale 1ns/100ps

module tppwm_gate_model (
  // Clock and reset.
  input wire logic         core_clk,
  input wire logic         rst,
  // Gate lines of legs 1 to 3 and the cycle marker.
  input wire logic [2:0]   main_n,
  input wire logic [2:0]   comp_n,
  input wire logic         cycle_sync_pulse,
  // Totals of the last complete cycle; shoot_cnt totals shoot-through clocks since reset.
  output logic [2:0][11:0] main_cnt,
  output logic [2:0][11:0] comp_cnt,
  output logic [11:0]      cyc_len,
  output logic [11:0]      shoot_cnt
);
  logic [2:0][11:0] main_acc;
  logic [2:0][11:0] comp_acc;
  logic [11:0]      len_acc;

  // Low lines conduct; both on in one leg would short the supply.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      main_acc  <= '0;
      comp_acc  <= '0;
      len_acc   <= '0;
      shoot_cnt <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        main_acc[i] <= (cycle_sync_pulse ? '0 : main_acc[i])
                       + {11'h000, !main_n[i]};
        comp_acc[i] <= (cycle_sync_pulse ? '0 : comp_acc[i])
                       + {11'h000, !comp_n[i]};
      end
      len_acc <= (cycle_sync_pulse ? '0 : len_acc) + 12'h001;
      if (cycle_sync_pulse) begin
        main_cnt <= main_acc;
        comp_cnt <= comp_acc;
        cyc_len  <= len_acc;
      end
      if (|(~main_n & ~comp_n)) begin
        shoot_cnt <= shoot_cnt + 12'h001;
      end
    end
  end
endmodule : tppwm_gate_model

// ==== tb/tppwm_timer_tb.sv ====
// Self-checking bench for the three-phase PWM timer.
// Assumes the design files, the package and the gate model are compiled.
`timescale 1ns/100ps
`include "tppwm_defines.svh"

module tppwm_timer_tb;
  import tppwm_pkg::*;

  logic             core_clk;
  logic             rst;
  logic             cs_n;
  logic             rd_n;
  logic             wr_n;
  logic             shutdown_in;
  logic             cycle_sync_pulse;
  logic             data_oe_n;
  logic             running;
  logic [3:0]       addr;
  tppwm_cnt_t       data_in;
  tppwm_cnt_t       data_out;
  logic [2:0]       main_n;
  logic [2:0]       comp_n;
  logic [2:0][11:0] main_cnt;
  logic [2:0][11:0] comp_cnt;
  logic [11:0]      cyc_len;
  logic [11:0]      shoot_cnt;
  logic [11:0]      p, d1, d2, d3;
  logic [6:0]       dt, mp;
  int               mismatches = 0;
  int               checks_done = 0;
  int               cycles = 0;

  tppwm_timer uut (
    .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .shutdown_in(shutdown_in),
    .leg1_out_n(main_n[0]), .leg1_complement_out_n(comp_n[0]),
    .leg2_out_n(main_n[1]), .leg2_complement_out_n(comp_n[1]),
    .leg3_out_n(main_n[2]), .leg3_complement_out_n(comp_n[2]),
    .cycle_sync_pulse(cycle_sync_pulse)
  );

  tppwm_gate_model drv (
    .core_clk(core_clk), .rst(rst), .main_n(main_n), .comp_n(comp_n),
    .cycle_sync_pulse(cycle_sync_pulse), .main_cnt(main_cnt),
    .comp_cnt(comp_cnt), .cyc_len(cyc_len), .shoot_cnt(shoot_cnt)
  );

  // 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Expected on-clocks; a deleted leg keeps its main off.
  function automatic logic [11:0] exp_main(logic [11:0] d, de, logic [6:0] m);
    return (d < {5'h00, m}) ? 12'h000 : d - de;
  endfunction : exp_main

  function automatic logic [11:0] exp_comp(logic [11:0] pv, d, de,
                                           logic [6:0] m);
    return (d < {5'h00, m}) ? pv : pv - d - de;
  endfunction : exp_comp

  task automatic check(string what, logic [11:0] exp, logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // Bus cycles: strobes held over exactly one sampling edge.
  task automatic wr(logic [3:0] a, logic [11:0] d);
    @(posedge core_clk);
    cs_n    <= 1'b0;
    wr_n    <= 1'b0;
    addr    <= a;
    data_in <= d;
    @(posedge core_clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
  endtask : wr

  task automatic rd(logic [3:0] a, logic [11:0] exp, string what);
    @(posedge core_clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    @(posedge core_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    #1;
    check(what, exp, data_out);
  endtask : rd

  // Returns one clock after a marker, once the model has its totals.
  task automatic wait_sync();
    int n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (cycle_sync_pulse !== 1'b1 && n < 5000);
    @(posedge core_clk);
    #1;
    if (n >= 5000) mismatches++;
  endtask : wait_sync

  // Loads a full setting, just after a marker once running, far ahead of the limit.
  task automatic run_case(logic [11:0] pv, a, b, c, logic [6:0] dl, m);
    logic [11:0] dv [3];
    logic [11:0] de;
    dv = '{a, b, c};
    de = {5'h00, dl & 7'h7E};
    if (running) wait_sync();
    wr(`TPPWM_ADDR_DEAD, {5'h00, dl});
    wr(`TPPWM_ADDR_MINP, {5'h00, m});
    wr(`TPPWM_ADDR_PERIOD, pv);
    wr(`TPPWM_ADDR_DUTY1, a);
    wr(`TPPWM_ADDR_DUTY2, b);
    wr(`TPPWM_ADDR_DUTY3, c);
    rd(`TPPWM_ADDR_DEAD, de, "deadtime");
    rd(`TPPWM_ADDR_MINP, {5'h00, m}, "min pulse");
    repeat (3) wait_sync();
    running = 1'b1;
    check("cycle length", pv, cyc_len);
    for (int i = 0; i < 3; i++) begin
      check("main on", exp_main(dv[i], de, m), main_cnt[i]);
      check("comp on", exp_comp(pv, dv[i], de, m), comp_cnt[i]);
    end
  endtask : run_case

  // Main sequence.
  initial begin
    rst         = 1'b1;
    cs_n        = 1'b1;
    rd_n        = 1'b1;
    wr_n        = 1'b1;
    addr        = 4'h0;
    data_in     = 12'h000;
    shutdown_in = 1'b0;
    running     = 1'b0;
    void'($urandom(32'h4B1B));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check("gates after reset", 12'h03F, {6'h00, main_n, comp_n});
    wr(4'h9, 12'hFFF);
    for (int i = 0; i < 16; i++) begin
      if (i < 6 || i > 7) rd(4'(i), 12'h000, "reset value");
    end
    wr(`TPPWM_ADDR_PERIOD, 12'h064);
    wr(`TPPWM_ADDR_DUTY1, 12'h032);
    wr(`TPPWM_ADDR_DUTY2, 12'h032);
    repeat (300) @(posedge core_clk);
    #1;
    check("gates partial set", 12'h03F, {6'h00, main_n, comp_n});
    // Leg 2 sits exactly on the threshold, leg 3 one below it.
    run_case(12'h064, 12'h032, 12'h014, 12'h013, 7'h06, 7'h14);
    wr(`TPPWM_ADDR_DUTY1, 12'h01E);
    repeat (3) wait_sync();
    check("duty held", 12'h02C, main_cnt[0]);
    wr(`TPPWM_ADDR_DUTY2, 12'h014);
    wr(`TPPWM_ADDR_DUTY3, 12'h013);
    repeat (3) wait_sync();
    check("duty applied", 12'h018, main_cnt[0]);
    repeat (20) @(posedge core_clk);
    shutdown_in <= 1'b1;
    @(posedge core_clk);
    #1;
    check("gates in shutdown", 12'h03F, {6'h00, main_n, comp_n});
    repeat (4) @(posedge core_clk);
    shutdown_in <= 1'b0;
    @(posedge core_clk);
    #1;
    check("deleted leg resumed", 12'h002, {10'h000, main_n[2], comp_n[2]});
    run_case(12'hFFF, 12'h7D0, 12'h07F, 12'h07E, 7'h7F, 7'h7F);
    for (int k = 0; k < 6; k++) begin
      p  = 12'(80 + $urandom % 121);
      dt = 7'($urandom % 16);
      mp = 7'(1 + $urandom % 20);
      d1 = 12'(36 + $urandom % (p - 51));
      d2 = 12'(36 + $urandom % (p - 51));
      d3 = k[0] ? 12'(mp) - 12'h001 : 12'(36 + $urandom % (p - 51));
      run_case(p, d1, d2, d3, dt, mp);
    end
    check("shoot through clocks", 12'h000, shoot_cnt);
    conclude();
  end

  // Ends a hung run.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 80000) begin
      mismatches++;
      conclude();
    end
  end
endmodule : tppwm_timer_tb
